// ==== pkg/bcu_pkg.sv ====
// constants, field layout and state encoding of the external bus control unit
// Operation
// (R1) each area group keeps its own width, wait and output-disable settings
// (R2) each group selects an 8-bit or 16-bit external data bus
// (R3) area 6 is 8-bit below 0x0380000 and 16-bit from there up
// (R4) each group inserts zero to seven programmed wait cycles
// (R5) writes always carry at least one wait cycle
// (R6) crossing to another area inserts the previous group's output-disable delay
// (R7) byte lane select mode bit chooses the x16 SRAM interface
// (R8) only areas 13, 14, 7 and 8 can be DRAM
// (R9) a set DRAM select bit gives the area DRAM cycles and strobes
// (R10) one shared DRAM timing and refresh set serves all DRAM areas; refresh here strobes only pins 3 and 4, so areas 7 and 8 on pin 2 get none
// (R11) first DRAM register: EDO, column width, refresh enable, mode, RPC, RAS width
// (R12) second DRAM register: successive RAS, precharge, CAS and RAS cycles
// (R13) refresh requests come from the 8-bit timer channel 0 underflow
// (R14) software waits or issues dummy cycles before using DRAM after power-up
// (R15) bus clock disable bit defaults to 0; when set the pin stays high
// (R16) two-bit field selects the bus clock source
// (R17) chip enable pin function 00 maps pins to areas 4 to 10
// (R18) function 01 and 1x map pins to the alternative and combined areas
// (R19) area 2 is 16-bit three-cycle, area 3 is 16-bit single-cycle
// (R20) internal I/O sits in area 1 and is mirrored above and below
// (R21) each access decodes its area, drives its chip enable and applies its group
package bcu_pkg;
	localparam logic [18:0] ADDR_GRP0 = 19'h48120;
	localparam logic [18:0] ADDR_GRP1 = 19'h48122;
	localparam logic [18:0] ADDR_GRP2 = 19'h48124;
	localparam logic [18:0] ADDR_GRP3 = 19'h48126;
	localparam logic [18:0] ADDR_DRAM_CFG = 19'h4812E;
	localparam logic [18:0] ADDR_DRAM_TIM = 19'h48130;
	localparam logic [18:0] ADDR_BCLK_SEL = 19'h4813A;
	// group byte in low and high half of each group register (group index)
	localparam logic [3:0][2:0] GRP_LO = {3'h4, 3'h6, 3'h2, 3'h0};
	localparam logic [3:0][2:0] GRP_HI = {3'h5, 3'h7, 3'h3, 3'h1};
	// only groups 14-13 and 8-7 carry the two DRAM select bits
	localparam logic [7:0][7:0] GRP_WMASK = {8'h3F, 8'h3F, 8'hFF, 8'h3F,
		8'h3F, 8'hFF, 8'h3F, 8'h3F};
	localparam int GF_WAIT = 0;
	localparam int GF_NARROW = 3;
	localparam int GF_ODLY = 4;
	localparam int GF_DSEL_HI = 6;
	localparam int GF_DSEL_LO = 7;
	localparam logic [7:0] RST_GRP = 8'h07;
	localparam int DC_EDO = 1;
	localparam int DC_BSL = 3;
	localparam int DC_COL = 4;
	localparam int DC_CBR = 6;
	localparam int DC_REF_EN = 7;
	localparam int DC_RPC = 8;
	localparam int DC_RASW = 9;
	localparam int DC_BCLK_OFF = 15;
	localparam int DT_RAS = 0;
	localparam int DT_CAS = 3;
	localparam int DT_PRE = 5;
	localparam int DT_SUCC = 7;
	localparam int DT_CEF = 9;
	localparam logic [15:0] RST_DRAM_CFG = 16'h0000;
	localparam logic [15:0] RST_DRAM_TIM = 16'h0000;
	localparam logic [1:0] RST_BCLK_SEL = 2'h0;
	localparam logic [27:0] AREA6_WIDE = 28'h0380000;
	localparam logic [27:0] INTIO_BASE = 28'h0040000;
	localparam logic [2:0] AREA2_CYCLES = 3'h3;
	localparam logic [2:0] AREA3_CYCLES = 3'h1;
	localparam logic [6:0] RAS_PINS = 7'h18;
	localparam logic [18:0][27:0] AREA_BASE = {
		28'hC000000, 28'h8000000, 28'h6000000, 28'h4000000, 28'h3000000,
		28'h2000000, 28'h1800000, 28'h1000000, 28'h0C00000, 28'h0800000,
		28'h0600000, 28'h0400000, 28'h0300000, 28'h0200000, 28'h0100000,
		28'h0080000, 28'h0060000, 28'h0030000, 28'h0000000};
	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_GAP = 7'h02,
		ST_ACC = 7'h04,
		ST_RAS = 7'h08,
		ST_CAS = 7'h10,
		ST_PRE = 7'h20,
		ST_REF = 7'h40
	} bcu_state_t;
endpackage : bcu_pkg

// ==== verilog/bcu_ctrl.sv ====
// external bus control unit: area decode, chip enables, SRAM and DRAM cycles
//
// Design decision made here: the plain strobed port.
`timescale 1ns/10ps
module bcu_ctrl #(
	parameter int INTIO_CYCLES = 2
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [18:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [27:0] req_addr,
	input wire logic [15:0] req_wdata,
	output logic busy,
	output logic ack,
	output logic [15:0] rsp_rdata,
	input wire logic tmr0_underflow,
	input wire logic [3:0] clk_src,
	output logic bus_clock_out,
	output logic [27:0] bus_addr,
	input wire logic [15:0] bus_data_in,
	output logic [15:0] bus_data_out,
	output logic bus_data_oe,
	output logic [6:0] chip_enable_n,
	output logic rd_n,
	output logic wr_n,
	output logic cas_n,
	output logic bus16,
	output logic byte_lane_select_mode,
	output logic int_sel,
	output logic [27:0] int_addr
);
	logic [7:0][7:0] grp_reg;
	logic [15:0] dram_cfg_reg;
	logic [15:0] dram_tim_reg;
	logic [1:0] bclk_sel_reg;
	logic [15:0] reg_rdata_reg;
	bcu_pkg::bcu_state_t state_reg;
	logic [2:0] cnt_reg;
	logic [27:0] cur_addr_reg;
	logic [4:0] cur_area_reg;
	logic cur_write_reg;
	logic [4:0] last_area_reg;
	logic last_ok_reg;
	logic [2:0] last_grp_reg;
	logic [2:0] cur_wait_reg;
	logic ref_pend_reg;
	logic ref_ras_reg;
	logic busy_reg;
	logic ack_reg;
	logic [15:0] rsp_rdata_reg;
	logic [27:0] bus_addr_reg;
	logic [15:0] bus_data_out_reg;
	logic bus_data_oe_reg;
	logic [6:0] ce_n_reg;
	logic rd_n_reg;
	logic wr_n_reg;
	logic cas_n_reg;
	logic bus16_reg;
	logic int_sel_reg;
	logic [27:0] int_addr_reg;
	logic [3:0] src_s1_reg;
	logic [3:0] src_s2_reg;
	logic [3:0] src_s3_reg;
	logic bclk_reg;
	logic [3:0] rd_len_reg;
	logic [4:0] req_area;
	logic [2:0] cur_grp;
	logic [7:0] cur_cfg;
	logic cur_dram;
	logic cur_wide;
	logic [1:0] cefunc;
	logic [6:0] cur_pins;
	logic [6:0] ref_pins;
	logic ref_start;

	function automatic logic [4:0] area_of(input logic [27:0] a);
		logic [4:0] r;
		r = 5'h00;
		for (int i = 1; i < 19; i++) begin
			if (a >= bcu_pkg::AREA_BASE[i]) begin
				r = 5'(i);
			end
		end
		return r;
	endfunction : area_of

	function automatic logic [2:0] grp_of(input logic [4:0] ar);
		case (ar)
			5'h11, 5'h12: grp_of = 3'h0;
			5'h0F, 5'h10: grp_of = 3'h1;
			5'h0D, 5'h0E: grp_of = 3'h2;
			5'h0B, 5'h0C: grp_of = 3'h3;
			5'h09, 5'h0A: grp_of = 3'h4;
			5'h07, 5'h08: grp_of = 3'h5;
			5'h06: grp_of = 3'h6;
			default: grp_of = 3'h7;
		endcase
	endfunction : grp_of

	// pin 0 is the first chip enable, pin 6 the area-10 chip enable
	function automatic logic [6:0] pins_of(input logic [4:0] ar, input logic [1:0] f);
		logic [6:0] m;
		m = 7'h00;
		if (f == 2'h0) begin
			if (ar >= 5'h04 && ar <= 5'h0A) begin
				m = 7'(7'h01 << (ar - 5'h04));
			end
		end else if (f == 2'h1) begin
			case (ar)
				5'h0B: m = 7'h01;
				5'h0F: m = 7'h02;
				5'h06: m = 7'h04;
				5'h0D: m = 7'h08;
				5'h0E: m = 7'h10;
				5'h11: m = 7'h20;
				5'h0A: m = 7'h40;
				default: m = 7'h00;
			endcase
		end else begin
			case (ar)
				5'h0B, 5'h0C: m = 7'h01;
				5'h0F, 5'h10: m = 7'h02;
				5'h07, 5'h08: m = 7'h04;
				5'h0D: m = 7'h08;
				5'h0E: m = 7'h10;
				5'h11, 5'h12: m = 7'h20;
				5'h09, 5'h0A: m = 7'h40;
				default: m = 7'h00;
			endcase
		end
		return m;
	endfunction : pins_of

	always_comb begin
		req_area = area_of(req_addr);
		cur_grp = grp_of(cur_area_reg);
		cur_cfg = grp_reg[cur_grp]; // see (R1)
		cefunc = dram_tim_reg[bcu_pkg::DT_CEF +: 2];
		cur_pins = pins_of(cur_area_reg, cefunc); // see (R17) see (R18)
		case (cur_area_reg) // see (R8) see (R9)
			5'h07, 5'h0D: cur_dram = cur_cfg[bcu_pkg::GF_DSEL_LO];
			5'h08, 5'h0E: cur_dram = cur_cfg[bcu_pkg::GF_DSEL_HI];
			default: cur_dram = 1'b0;
		endcase
		if (cur_area_reg < 5'h04) begin
			cur_wide = 1'b1; // see (R19)
		end else if (cur_area_reg == 5'h06) begin
			cur_wide = (cur_addr_reg >= bcu_pkg::AREA6_WIDE); // see (R3)
		end else begin
			cur_wide = !cur_cfg[bcu_pkg::GF_NARROW]; // see (R2)
		end
		// every selected DRAM area on pin 3 or 4 shares one refresh; areas 7 and 8 on pin 2 get none
		ref_pins = bcu_pkg::RAS_PINS & (
			(grp_reg[2][bcu_pkg::GF_DSEL_LO] ? pins_of(5'h0D, cefunc) : 7'h00) |
			(grp_reg[2][bcu_pkg::GF_DSEL_HI] ? pins_of(5'h0E, cefunc) : 7'h00) |
			(grp_reg[5][bcu_pkg::GF_DSEL_LO] ? pins_of(5'h07, cefunc) : 7'h00) |
			(grp_reg[5][bcu_pkg::GF_DSEL_HI] ? pins_of(5'h08, cefunc) : 7'h00));
		ref_start = (state_reg == bcu_pkg::ST_IDLE) && !req_valid && ref_pend_reg &&
			dram_cfg_reg[bcu_pkg::DC_REF_EN];
	end

	// register writes
	always_ff @(posedge clk) begin
		if (rst) begin
			grp_reg <= {8{bcu_pkg::RST_GRP}};
			dram_cfg_reg <= bcu_pkg::RST_DRAM_CFG; // see (R15)
			dram_tim_reg <= bcu_pkg::RST_DRAM_TIM; // see (R17)
			bclk_sel_reg <= bcu_pkg::RST_BCLK_SEL;
		end else if (reg_wr) begin
			if (reg_addr == bcu_pkg::ADDR_DRAM_CFG) begin
				dram_cfg_reg <= reg_wdata; // see (R11) see (R7)
			end else if (reg_addr == bcu_pkg::ADDR_DRAM_TIM) begin
				dram_tim_reg <= reg_wdata; // see (R12)
			end else if (reg_addr == bcu_pkg::ADDR_BCLK_SEL) begin
				bclk_sel_reg <= reg_wdata[1:0]; // see (R16)
			end else begin
				for (int k = 0; k < 4; k++) begin
					if (reg_addr == bcu_pkg::ADDR_GRP0 + 19'(2 * k)) begin
						grp_reg[bcu_pkg::GRP_LO[k]] <= reg_wdata[7:0] &
							bcu_pkg::GRP_WMASK[bcu_pkg::GRP_LO[k]];
						grp_reg[bcu_pkg::GRP_HI[k]] <= reg_wdata[15:8] &
							bcu_pkg::GRP_WMASK[bcu_pkg::GRP_HI[k]];
					end
				end
			end
		end
	end

	// register reads, data in the cycle after the strobe; unmapped reads zero
	always_ff @(posedge clk) begin
		if (rst) begin
			reg_rdata_reg <= 16'h0000;
		end else if (reg_rd) begin
			if (reg_addr == bcu_pkg::ADDR_DRAM_CFG) begin
				reg_rdata_reg <= dram_cfg_reg;
			end else if (reg_addr == bcu_pkg::ADDR_DRAM_TIM) begin
				reg_rdata_reg <= dram_tim_reg;
			end else if (reg_addr == bcu_pkg::ADDR_BCLK_SEL) begin
				reg_rdata_reg <= {14'h0000, bclk_sel_reg};
			end else if (reg_addr == bcu_pkg::ADDR_GRP0) begin
				reg_rdata_reg <= {grp_reg[1], grp_reg[0]};
			end else if (reg_addr == bcu_pkg::ADDR_GRP1) begin
				reg_rdata_reg <= {grp_reg[3], grp_reg[2]};
			end else if (reg_addr == bcu_pkg::ADDR_GRP2) begin
				reg_rdata_reg <= {grp_reg[7], grp_reg[6]};
			end else if (reg_addr == bcu_pkg::ADDR_GRP3) begin
				reg_rdata_reg <= {grp_reg[5], grp_reg[4]};
			end else begin
				reg_rdata_reg <= 16'h0000;
			end
		end else begin
			reg_rdata_reg <= 16'h0000;
		end
	end

	// clock sources are foreign, so each passes three flops before use
	always_ff @(posedge clk) begin
		if (rst) begin
			src_s1_reg <= 4'h0;
			src_s2_reg <= 4'h0;
			src_s3_reg <= 4'h0;
			bclk_reg <= 1'b1;
		end else begin
			src_s1_reg <= clk_src;
			src_s2_reg <= src_s1_reg;
			src_s3_reg <= src_s2_reg;
			if (dram_cfg_reg[bcu_pkg::DC_BCLK_OFF]) begin
				bclk_reg <= 1'b1; // see (R15)
			end else if (src_s2_reg[bclk_sel_reg] == src_s3_reg[bclk_sel_reg]) begin
				bclk_reg <= src_s3_reg[bclk_sel_reg]; // see (R16)
			end
		end
	end

	// a timer underflow in the same cycle as the refresh start is kept pending
	always_ff @(posedge clk) begin
		if (rst) begin
			ref_pend_reg <= 1'b0;
		end else if (tmr0_underflow) begin
			ref_pend_reg <= 1'b1; // see (R13)
		end else if (ref_start) begin
			ref_pend_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= bcu_pkg::ST_IDLE;
			cnt_reg <= 3'h0;
			cur_addr_reg <= 28'h0000000;
			cur_area_reg <= 5'h00;
			cur_write_reg <= 1'b0;
			cur_wait_reg <= 3'h0;
			last_area_reg <= 5'h00;
			last_ok_reg <= 1'b0;
			last_grp_reg <= 3'h0;
			ref_ras_reg <= 1'b0;
			busy_reg <= 1'b0;
			ack_reg <= 1'b0;
			rsp_rdata_reg <= 16'h0000;
			bus_addr_reg <= 28'h0000000;
			bus_data_out_reg <= 16'h0000;
			bus_data_oe_reg <= 1'b0;
			ce_n_reg <= 7'h7F;
			rd_n_reg <= 1'b1;
			wr_n_reg <= 1'b1;
			cas_n_reg <= 1'b1;
			bus16_reg <= 1'b1;
			int_sel_reg <= 1'b0;
			int_addr_reg <= 28'h0000000;
		end else begin
			ack_reg <= 1'b0;
			case (state_reg)
				bcu_pkg::ST_IDLE: begin
					if (req_valid) begin
						cur_addr_reg <= req_addr;
						cur_area_reg <= req_area;
						cur_write_reg <= req_write;
						bus_addr_reg <= req_addr;
						bus_data_out_reg <= req_wdata;
						busy_reg <= 1'b1;
						if (req_area >= 5'h04 && last_ok_reg && req_area != last_area_reg) begin
							cnt_reg <= {1'b0, grp_reg[last_grp_reg][bcu_pkg::GF_ODLY +: 2]} +
								3'h1; // see (R6)
						end else begin
							cnt_reg <= 3'h0;
						end
						state_reg <= bcu_pkg::ST_GAP;
					end else if (ref_start) begin
						busy_reg <= 1'b1;
						cas_n_reg <= 1'b0; // CAS before RAS
						ref_ras_reg <= 1'b0;
						cnt_reg <= dram_cfg_reg[bcu_pkg::DC_RPC] ? 3'h1 : 3'h0; // see (R11)
						state_reg <= bcu_pkg::ST_REF;
					end
				end
				bcu_pkg::ST_GAP: begin
					if (cnt_reg != 3'h0) begin
						cnt_reg <= cnt_reg - 3'h1;
					end else begin
						bus16_reg <= cur_wide;
						last_area_reg <= cur_area_reg;
						last_grp_reg <= cur_grp;
						last_ok_reg <= (cur_area_reg >= 5'h04);
						if (cur_area_reg < 5'h04) begin
							int_sel_reg <= 1'b1;
							int_addr_reg <= bcu_pkg::INTIO_BASE | {12'h000, cur_addr_reg[15:0]}; // see (R20)
							if (cur_area_reg == 5'h01) begin
								cnt_reg <= 3'(INTIO_CYCLES - 1);
							end else if (cur_area_reg == 5'h02) begin
								cnt_reg <= bcu_pkg::AREA2_CYCLES - 3'h1; // see (R19)
							end else begin
								cnt_reg <= bcu_pkg::AREA3_CYCLES - 3'h1;
							end
							cur_wait_reg <= 3'h0;
							state_reg <= bcu_pkg::ST_ACC;
						end else if (cur_dram) begin
							ce_n_reg <= ~cur_pins; // see (R9) see (R21)
							cnt_reg <= dram_tim_reg[bcu_pkg::DT_RAS +: 3] &
								3'h3; // see (R10) see (R12)
							state_reg <= bcu_pkg::ST_RAS;
						end else begin
							ce_n_reg <= ~cur_pins; // see (R21)
							rd_n_reg <= cur_write_reg;
							wr_n_reg <= !cur_write_reg;
							bus_data_oe_reg <= cur_write_reg;
							if (cur_write_reg && cur_cfg[2:0] == 3'h0) begin
								cnt_reg <= 3'h1; // see (R5)
							end else begin
								cnt_reg <= cur_cfg[2:0]; // see (R4)
							end
							cur_wait_reg <= cur_cfg[2:0];
							state_reg <= bcu_pkg::ST_ACC;
						end
					end
				end
				bcu_pkg::ST_ACC: begin
					if (cnt_reg != 3'h0) begin
						cnt_reg <= cnt_reg - 3'h1;
					end else begin
						ce_n_reg <= 7'h7F;
						rd_n_reg <= 1'b1;
						wr_n_reg <= 1'b1;
						bus_data_oe_reg <= 1'b0;
						int_sel_reg <= 1'b0;
						rsp_rdata_reg <= bus_data_in;
						ack_reg <= 1'b1;
						busy_reg <= 1'b0;
						state_reg <= bcu_pkg::ST_IDLE;
					end
				end
				bcu_pkg::ST_RAS: begin
					if (cnt_reg != 3'h0) begin
						cnt_reg <= cnt_reg - 3'h1;
					end else begin
						cas_n_reg <= 1'b0;
						rd_n_reg <= cur_write_reg;
						wr_n_reg <= !cur_write_reg;
						bus_data_oe_reg <= cur_write_reg;
						cnt_reg <= {1'b0, dram_tim_reg[bcu_pkg::DT_CAS +: 2]}; // see (R12)
						state_reg <= bcu_pkg::ST_CAS;
					end
				end
				bcu_pkg::ST_CAS: begin
					if (cnt_reg != 3'h0) begin
						cnt_reg <= cnt_reg - 3'h1;
					end else begin
						ce_n_reg <= 7'h7F;
						cas_n_reg <= 1'b1;
						rd_n_reg <= 1'b1;
						wr_n_reg <= 1'b1;
						bus_data_oe_reg <= 1'b0;
						rsp_rdata_reg <= bus_data_in;
						ack_reg <= 1'b1;
						cnt_reg <= {1'b0, dram_tim_reg[bcu_pkg::DT_PRE +: 2]}; // see (R12)
						state_reg <= bcu_pkg::ST_PRE;
					end
				end
				bcu_pkg::ST_PRE: begin
					if (cnt_reg != 3'h0) begin
						cnt_reg <= cnt_reg - 3'h1;
					end else begin
						busy_reg <= 1'b0;
						state_reg <= bcu_pkg::ST_IDLE;
					end
				end
				bcu_pkg::ST_REF: begin
					if (cnt_reg != 3'h0) begin
						cnt_reg <= cnt_reg - 3'h1;
					end else if (!ref_ras_reg) begin
						ce_n_reg <= ~ref_pins; // see (R10)
						ref_ras_reg <= 1'b1;
						cnt_reg <= {1'b0, dram_cfg_reg[bcu_pkg::DC_RASW +: 2]} +
							3'h1; // see (R11)
					end else if (!dram_cfg_reg[bcu_pkg::DC_CBR] &&
						dram_cfg_reg[bcu_pkg::DC_REF_EN]) begin
						// self refresh holds the strobes until software leaves the mode
						ce_n_reg <= ~ref_pins;
					end else begin
						ce_n_reg <= 7'h7F;
						cas_n_reg <= 1'b1;
						ref_ras_reg <= 1'b0;
						cnt_reg <= {1'b0, dram_tim_reg[bcu_pkg::DT_PRE +: 2]};
						state_reg <= bcu_pkg::ST_PRE;
					end
				end
				default: begin
					state_reg <= bcu_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// length of each read strobe, watched by the read length check below
	always_ff @(posedge clk) begin
		if (rst) begin
			rd_len_reg <= 4'h0;
		end else if (!rd_n_reg) begin
			rd_len_reg <= rd_len_reg + 4'h1;
		end else begin
			rd_len_reg <= 4'h0;
		end
	end

	assign reg_rdata = reg_rdata_reg;
	assign busy = busy_reg;
	assign ack = ack_reg;
	assign rsp_rdata = rsp_rdata_reg;
	assign bus_clock_out = bclk_reg;
	assign bus_addr = bus_addr_reg;
	assign bus_data_out = bus_data_out_reg;
	assign bus_data_oe = bus_data_oe_reg;
	assign chip_enable_n = ce_n_reg;
	assign rd_n = rd_n_reg;
	assign wr_n = wr_n_reg;
	assign cas_n = cas_n_reg;
	assign bus16 = bus16_reg;
	assign byte_lane_select_mode = dram_cfg_reg[bcu_pkg::DC_BSL];
	assign int_sel = int_sel_reg;
	assign int_addr = int_addr_reg;

	a_write_min_wait: assert property (@(posedge clk) disable iff (rst) // see (R5)
		$fell(wr_n_reg) && state_reg == bcu_pkg::ST_ACC |=> !wr_n_reg)
		else $error("write strobe shorter than two cycles");
	a_read_wait_len: assert property (@(posedge clk) disable iff (rst) // see (R4)
		$rose(rd_n_reg) && $past(state_reg) == bcu_pkg::ST_ACC |->
		rd_len_reg == 4'(cur_wait_reg) + 4'h1)
		else $error("read strobe length differs from wait setting");
	a_bclk_held_high: assert property (@(posedge clk) disable iff (rst) // see (R15)
		dram_cfg_reg[bcu_pkg::DC_BCLK_OFF] |=> bus_clock_out)
		else $error("bus clock not held high while disabled");
	a_ce_single_pin: assert property (@(posedge clk) disable iff (rst) // see (R21)
		state_reg == bcu_pkg::ST_ACC |-> $onehot0(~ce_n_reg))
		else $error("more than one chip enable active");
	a_area6_width: assert property (@(posedge clk) disable iff (rst) // see (R3)
		state_reg == bcu_pkg::ST_ACC && cur_area_reg == 5'h06 |->
		bus16_reg == (cur_addr_reg >= bcu_pkg::AREA6_WIDE))
		else $error("area 6 width wrong for address");
	a_dram_area_only: assert property (@(posedge clk) disable iff (rst) // see (R8)
		state_reg == bcu_pkg::ST_RAS |-> cur_area_reg inside {5'h07, 5'h08, 5'h0D, 5'h0E})
		else $error("DRAM cycle outside a DRAM capable area");
	a_gap_no_enable: assert property (@(posedge clk) disable iff (rst) // see (R6)
		state_reg == bcu_pkg::ST_GAP && cnt_reg != 3'h0 |-> ce_n_reg == 7'h7F ##1
		ce_n_reg == 7'h7F)
		else $error("chip enable active during output disable delay");
	a_refresh_start: assert property (@(posedge clk) disable iff (rst) // see (R13)
		ref_start |=> state_reg == bcu_pkg::ST_REF && !cas_n_reg)
		else $error("pending refresh not started");
	a_internal_fixed: assert property (@(posedge clk) disable iff (rst) // see (R19)
		state_reg == bcu_pkg::ST_GAP && cnt_reg == 3'h0 && cur_area_reg == 5'h02 |=>
		int_sel_reg [*3] ##1 !int_sel_reg)
		else $error("area 2 access not three cycles");
endmodule : bcu_ctrl

// ==== tb/bcu_ext_mem.sv ====
// external memory model answering reads on the far side of the bus unit
`timescale 1ns/10ps
module bcu_ext_mem #(
	parameter logic [15:0] SCRAMBLE = 16'hA5C3
) (
	input wire logic clk,
	input wire logic [6:0] chip_enable_n,
	input wire logic rd_n,
	input wire logic [27:0] bus_addr,
	output logic [15:0] bus_data_in
);
	logic [15:0] last_reg = 16'h0000;
	logic drive;
	// a released bus shows the inverse of its last value, so a stale sample never matches
	assign drive = (chip_enable_n != 7'h7F) && (rd_n == 1'h0);
	assign bus_data_in = drive ? (bus_addr[15:0] ^ SCRAMBLE) : ~last_reg;
	always @(posedge clk) begin
		last_reg <= bus_data_in;
	end
endmodule : bcu_ext_mem

// ==== tb/external_bus_control_unit_test.sv ====
// self-checking bench of the external bus control unit against an external memory model
`timescale 1ns/10ps
module external_bus_control_unit_test;
	logic clk = 1'h0;
	logic rst, reg_wr, reg_rd, req_valid, req_write, busy, ack, tmr0_underflow, bus_clock_out;
	logic bus_data_oe, rd_n, wr_n, cas_n, bus16, byte_lane_select_mode, int_sel;
	logic [18:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, req_wdata, rsp_rdata, bus_data_in, bus_data_out, dout;
	logic [27:0] req_addr, bus_addr, int_addr, iaddr;
	logic [3:0] clk_src;
	logic [6:0] chip_enable_n, ce_seen;
	logic cas_seen, b16, oe_seen;
	int err_count = 0;
	int comparisons = 0;
	int strobes, first, int_cnt;

	always #5 clk = ~clk;

	bcu_ctrl #(.INTIO_CYCLES(2)) i_bcu_ctrl (.clk(clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
		.req_wdata(req_wdata), .busy(busy), .ack(ack), .rsp_rdata(rsp_rdata),
		.tmr0_underflow(tmr0_underflow), .clk_src(clk_src), .bus_clock_out(bus_clock_out),
		.bus_addr(bus_addr), .bus_data_in(bus_data_in), .bus_data_out(bus_data_out),
		.bus_data_oe(bus_data_oe), .chip_enable_n(chip_enable_n), .rd_n(rd_n), .wr_n(wr_n),
		.cas_n(cas_n), .bus16(bus16), .byte_lane_select_mode(byte_lane_select_mode),
		.int_sel(int_sel), .int_addr(int_addr));

	bcu_ext_mem i_bcu_ext_mem (.clk(clk), .chip_enable_n(chip_enable_n), .rd_n(rd_n),
		.bus_addr(bus_addr), .bus_data_in(bus_data_in));

	task automatic chk(input logic [27:0] got, input logic [27:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t ns mismatch got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr_reg(input logic [18:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge clk);
		reg_wr <= 1'h0;
	endtask : wr_reg

	task automatic rd_chk(input logic [18:0] a, input logic [15:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge clk);
		reg_rd <= 1'h0;
		#1;
		chk(28'(reg_rdata), 28'(exp));
	endtask : rd_chk

	// one access; records strobe count, first strobe cycle and what the pins showed
	task automatic acc(input logic wr, input logic [27:0] a, input logic [15:0] d);
		int n;
		bit fin;
		fin = 0;
		strobes = 0;
		first = 0;
		int_cnt = 0;
		ce_seen = 7'h00;
		cas_seen = 1'h0;
		oe_seen = 1'h0;
		for (n = 0; n < 50 && busy !== 1'h0; n++) begin
			@(posedge clk);
			#1;
		end
		@(posedge clk);
		req_valid <= 1'h1;
		req_write <= wr;
		req_addr <= a;
		req_wdata <= d;
		@(posedge clk);
		req_valid <= 1'h0;
		for (n = 1; n < 60 && !fin; n++) begin
			#1;
			if (rd_n === 1'h0 || wr_n === 1'h0) begin
				if (first == 0)
					first = n;
				strobes++;
				b16 = bus16;
				oe_seen |= bus_data_oe;
				dout = bus_data_out;
			end
			if (int_sel === 1'h1) begin
				int_cnt++;
				iaddr = int_addr;
			end
			ce_seen |= ~chip_enable_n;
			cas_seen |= ~cas_n;
			fin = (ack === 1'h1);
			if (!fin)
				@(posedge clk);
		end
		if (!fin)
			chk(28'h0, 28'h1);
	endtask : acc

	task automatic t_regs;
		rd_chk(19'h48122, 16'h0707);
		rd_chk(19'h4812E, 16'h0000);
		rd_chk(19'h48130, 16'h0000);
		rd_chk(19'h4813A, 16'h0000);
		wr_reg(19'h48128, 16'hFFFF);
		rd_chk(19'h48128, 16'h0000);
		wr_reg(19'h48124, 16'hFFFF);
		rd_chk(19'h48124, 16'h3F3F);
		wr_reg(19'h48122, 16'hFFFF);
		rd_chk(19'h48122, 16'h3FFF);
		wr_reg(19'h48124, 16'h0707);
		wr_reg(19'h48122, 16'h0707);
		$display("test regs done");
	endtask : t_regs

	task automatic t_wait;
		for (int w = 0; w < 8; w++) begin
			wr_reg(19'h48126, 16'h0700 | 16'(w));
			acc(1'h0, 28'h0C00010 + 28'(w), 16'h0000);
			chk(28'(strobes), 28'(w + 1));
			chk(28'({ce_seen, b16}), 28'({7'h40, 1'h1}));
			chk(28'(rsp_rdata), 28'((16'h0010 + 16'(w)) ^ 16'hA5C3));
			acc(1'h1, 28'h0C00020, 16'h5AA5 + 16'(w));
			chk(28'(strobes), 28'((w > 0 ? w : 1) + 1));
			chk(28'({oe_seen, dout}), 28'({1'h1, 16'h5AA5 + 16'(w)}));
		end
		$display("test wait done");
	endtask : t_wait

	task automatic t_width;
		wr_reg(19'h48126, 16'h0709);
		acc(1'h0, 28'h0C00000, 16'h0000);
		chk(28'(b16), 28'h0);
		acc(1'h0, 28'h037FFFE, 16'h0000);
		chk(28'({ce_seen, b16}), 28'({7'h04, 1'h0}));
		acc(1'h0, 28'h0380000, 16'h0000);
		chk(28'(b16), 28'h1);
		$display("test width done");
	endtask : t_width

	task automatic t_odly;
		wr_reg(19'h48126, 16'h0721);
		acc(1'h0, 28'h0C00000, 16'h0000);
		acc(1'h0, 28'h0C00002, 16'h0000);
		chk(28'(first), 28'h2);
		// leaving area 10 costs its delay code 2 plus one clock
		acc(1'h0, 28'h0100000, 16'h0000);
		chk(28'(first), 28'h5);
		$display("test odly done");
	endtask : t_odly

	task automatic t_cefunc;
		logic [27:0] ad [5] = '{28'h0100000, 28'h1000000, 28'h8000000, 28'h1800000, 28'h7000000};
		logic [1:0] fn [5] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h3};
		logic [6:0] pin [5] = '{7'h01, 7'h01, 7'h20, 7'h01, 7'h02};
		for (int i = 0; i < 5; i++) begin
			wr_reg(19'h48130, {5'h00, fn[i], 9'h000});
			acc(1'h0, ad[i], 16'h0000);
			chk(28'(ce_seen), 28'(pin[i]));
		end
		$display("test cefunc done");
	endtask : t_cefunc

	task automatic t_int;
		acc(1'h0, 28'h0060000, 16'h0000);
		chk(28'({ce_seen, 8'(int_cnt)}), 28'h003);
		acc(1'h0, 28'h0080000, 16'h0000);
		chk(28'(int_cnt), 28'h1);
		acc(1'h0, 28'h0050010, 16'h0000);
		chk(28'(int_cnt), 28'h2);
		chk(iaddr, 28'h0040010);
		acc(1'h0, 28'h0030010, 16'h0000);
		chk(iaddr, 28'h0040010);
		$display("test internal done");
	endtask : t_int

	task automatic t_bclk;
		for (int s = 0; s < 4; s++) begin
			wr_reg(19'h4813A, 16'(s));
			clk_src <= 4'h1 << s;
			repeat (6) @(posedge clk);
			#1;
			chk(28'(bus_clock_out), 28'h1);
			@(posedge clk);
			clk_src <= ~(4'h1 << s);
			repeat (6) @(posedge clk);
			#1;
			chk(28'(bus_clock_out), 28'h0);
		end
		wr_reg(19'h4812E, 16'h8008);
		repeat (6) @(posedge clk);
		#1;
		chk(28'({bus_clock_out, byte_lane_select_mode}), 28'h3);
		wr_reg(19'h4812E, 16'h0000);
		$display("test bclk done");
	endtask : t_bclk

	task automatic pulse_watch;
		@(posedge clk);
		tmr0_underflow <= 1'h1;
		@(posedge clk);
		tmr0_underflow <= 1'h0;
		cas_seen = 1'h0;
		repeat (20) begin
			@(posedge clk);
			#1;
			cas_seen |= ~cas_n;
		end
	endtask : pulse_watch

	task automatic t_dram;
		wr_reg(19'h48130, 16'h0208);
		wr_reg(19'h48122, 16'h0780);
		// power-up dummy time before the first DRAM cycle
		repeat (8) @(posedge clk);
		acc(1'h0, 28'h2000020, 16'h0000);
		chk(28'({cas_seen, ce_seen}), 28'({1'h1, 7'h08}));
		chk(28'(strobes), 28'h2);
		chk(28'(rsp_rdata), 28'(16'h0020 ^ 16'hA5C3));
		// ack comes with the start of the precharge, which still keeps the unit busy
		chk(28'(busy), 28'h1);
		acc(1'h0, 28'h3000020, 16'h0000);
		chk(28'({cas_seen, ce_seen}), 28'({1'h0, 7'h10}));
		wr_reg(19'h4812E, 16'h00C0);
		pulse_watch;
		chk(28'(cas_seen), 28'h1);
		// self refresh with two-cycle delay holds CAS and the RAS pin until the mode changes
		wr_reg(19'h4812E, 16'h0180);
		pulse_watch;
		chk(28'({cas_seen, cas_n, chip_enable_n}), 28'({1'h1, 1'h0, 7'h77}));
		wr_reg(19'h4812E, 16'h0040);
		pulse_watch;
		chk(28'(cas_seen), 28'h0);
		$display("test dram done");
	endtask : t_dram

	task automatic final_report;
		$display("mismatches %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : final_report

	initial begin
		rst = 1'h1;
		reg_addr = 19'h00000;
		reg_wdata = 16'h0000;
		reg_wr = 1'h0;
		reg_rd = 1'h0;
		req_valid = 1'h0;
		req_write = 1'h0;
		req_addr = 28'h0000000;
		req_wdata = 16'h0000;
		tmr0_underflow = 1'h0;
		clk_src = 4'h0;
		repeat (6) @(posedge clk);
		rst <= 1'h0;
		t_regs;
		t_wait;
		t_width;
		t_odly;
		t_cefunc;
		t_int;
		t_bclk;
		t_dram;
		final_report;
	end

	initial begin
		repeat (30000) @(posedge clk);
		err_count++;
		final_report;
	end
endmodule : external_bus_control_unit_test
